// [verilog/epiu_top.sv]
// external pin and pin-change interrupt unit with apb registers
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module epiu_top (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  ext_irq_pin,
  input  wire logic [31:0] pin_change_input,
  input  wire logic        global_irq_en,
  input  wire logic        sleep_en,
  input  wire logic        sleep_idle,
  input  wire logic        startup_busy,
  input  wire logic [2:0]  ext_irq_ack,
  input  wire logic [3:0]  pc_group_ack,
  output logic      [2:0]  ext_irq_req,
  output logic      [3:0]  pc_group_req,
  output logic             wake_req
);

  localparam int unsigned NEXT = epiu_pkg::EPIU_NEXT;
  localparam int unsigned NGRP = epiu_pkg::EPIU_NGRP;
  localparam int unsigned GRPW = epiu_pkg::EPIU_GRPW;
  localparam int unsigned NPC  = epiu_pkg::EPIU_NPC;

  // register state
  logic [5:0]      sense_q;
  logic [2:0]      ext_mask_q;
  logic [2:0]      ext_flag_q;
  logic [3:0]      grp_en_q;
  logic [3:0]      pc_flag_q;
  logic [7:0]      pc_mask_q [NGRP];
  logic [31:0]     prdata_q;
  logic [1:0]      prime_q;
  logic            armed;

  // pin sampling
  logic [2:0]      ext_pin_s;
  logic [31:0]     pc_pin_s;
  logic [31:0]     pc_prev_q;
  logic [31:0]     pc_mask_flat;
  logic [31:0]     pc_change;
  logic [3:0]      pc_grp_hit;

  // per pin sense results
  logic [2:0]      ext_trig;
  logic [2:0]      ext_level;
  logic [2:0]      ext_is_level;
  logic [1:0]      pin_sense [NEXT];

  // bus decode
  logic [7:0]      idx;
  logic            addr_ok;
  logic            is_pc_mask;
  logic [1:0]      pc_mask_sel;
  logic            hit;
  logic            setup;
  logic            access;
  logic            wr;
  logic [31:0]     rd_mux;

  logic            io_en;
  logic [2:0]      level_wake;
  logic [3:0]      pc_wake;

  // io clock runs when awake or in idle sleep
  assign io_en = ~sleep_en | sleep_idle;

  // ---------------------------------------------------------------
  // pin synchronisers; interrupt flags read pins through these, wake-up reads the raw pins
  // ---------------------------------------------------------------
  epiu_sync #(
    .W (NEXT)
  ) u_sync_ext (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .ce      (ce),
    .din     (ext_irq_pin),
    .dout    (ext_pin_s)
  );

  epiu_sync #(
    .W (NPC)
  ) u_sync_pc (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .ce      (ce),
    .din     (pin_change_input),
    .dout    (pc_pin_s)
  );

  // detection held off until the sample pipeline is full
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prime_q <= 2'h0;
    end else if (ce && prime_q != epiu_pkg::EPIU_PRIME_CYCLES) begin
      prime_q <= prime_q + 2'h1;
    end
  end

  assign armed = (prime_q == epiu_pkg::EPIU_PRIME_CYCLES);

  // ---------------------------------------------------------------
  // dedicated pins
  // ---------------------------------------------------------------
  assign pin_sense[0] = sense_q[epiu_pkg::EPIU_SENSE_POS0 +: epiu_pkg::EPIU_SENSE_W];
  assign pin_sense[1] = sense_q[epiu_pkg::EPIU_SENSE_POS1 +: epiu_pkg::EPIU_SENSE_W];
  assign pin_sense[2] = sense_q[epiu_pkg::EPIU_SENSE_POS2 +: epiu_pkg::EPIU_SENSE_W];

  generate
    for (genvar i = 0; i < NEXT; i++) begin : g_ext
      epiu_edge_sense u_sense (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .ce        (ce),
        .io_en     (io_en),
        .armed     (armed),
        .pin_s     (ext_pin_s[i]),
        .sense     (pin_sense[i]),
        .trig      (ext_trig[i]),
        .level_low (ext_level[i])
      );
      assign ext_is_level[i] = (pin_sense[i] == epiu_pkg::EPIU_SENSE_LOW);
    end
  endgenerate

  // edge flags: set beats clear, level mode forces clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ext_flag_q <= epiu_pkg::EPIU_RST_EXT_FLAG;
    end else if (ce) begin
      for (int i = 0; i < NEXT; i++) begin
        if (ext_is_level[i]) begin
          ext_flag_q[i] <= 1'b0;
        end else if (ext_trig[i]) begin
          ext_flag_q[i] <= 1'b1;
        end else if (ext_irq_ack[i]) begin
          ext_flag_q[i] <= 1'b0;
        end else if (wr && idx == epiu_pkg::EPIU_IDX_EXT_FLAG && pwdata[i]) begin
          ext_flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // level requests are live and wait for the oscillator start-up
  always_comb begin
    for (int i = 0; i < NEXT; i++) begin
      if (ext_is_level[i]) begin
        ext_irq_req[i] = global_irq_en & ext_mask_q[i] & armed & ext_level[i] & ~startup_busy;
      end else begin
        ext_irq_req[i] = global_irq_en & ext_mask_q[i] & ext_flag_q[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // pin-change banks
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pc_prev_q <= 32'h00000000;
    end else if (ce) begin
      pc_prev_q <= pc_pin_s;
    end
  end

  generate
    for (genvar g = 0; g < NGRP; g++) begin : g_pc
      assign pc_mask_flat[g*GRPW +: GRPW] = pc_mask_q[g];
      assign pc_grp_hit[g] = armed & |pc_change[g*GRPW +: GRPW];
      // clockless view: raw pin against last sampled value
      assign pc_wake[g] = grp_en_q[g] &
        |(pc_mask_q[g] & (pin_change_input[g*GRPW +: GRPW] ^ pc_prev_q[g*GRPW +: GRPW]));
    end
  endgenerate

  assign pc_change = (pc_pin_s ^ pc_prev_q) & pc_mask_flat;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pc_flag_q <= epiu_pkg::EPIU_RST_PC_FLAG;
    end else if (ce) begin
      for (int g = 0; g < NGRP; g++) begin
        if (pc_grp_hit[g]) begin
          pc_flag_q[g] <= 1'b1;
        end else if (pc_group_ack[g]) begin
          pc_flag_q[g] <= 1'b0;
        end else if (wr && idx == epiu_pkg::EPIU_IDX_PC_FLAG && pwdata[g]) begin
          pc_flag_q[g] <= 1'b0;
        end
      end
    end
  end

  assign pc_group_req = pc_flag_q & grp_en_q & {NGRP{global_irq_en}};

  // ---------------------------------------------------------------
  // wake-up: combinational from the raw pins, needs no clock
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NEXT; i++) begin
      level_wake[i] = ext_is_level[i] & ext_mask_q[i] & ~ext_irq_pin[i];
    end
  end

  assign wake_req = global_irq_en & (|level_wake | |pc_wake);

  // ---------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------
  assign idx     = paddr[9:2];
  assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  assign setup   = psel & ~penable;
  assign access  = psel & penable;

  assign is_pc_mask  = (idx >= epiu_pkg::EPIU_IDX_PC_MASK0) &&
                       (idx < epiu_pkg::EPIU_IDX_PC_MASK0 + 8'h04);
  assign pc_mask_sel = 2'(idx - epiu_pkg::EPIU_IDX_PC_MASK0);

  always_comb begin
    hit = 1'b0;
    if (addr_ok) begin
      case (idx)
        epiu_pkg::EPIU_IDX_PC_FLAG:  hit = 1'b1;
        epiu_pkg::EPIU_IDX_EXT_FLAG: hit = 1'b1;
        epiu_pkg::EPIU_IDX_EXT_MASK: hit = 1'b1;
        epiu_pkg::EPIU_IDX_GRP_EN:   hit = 1'b1;
        epiu_pkg::EPIU_IDX_SENSE:    hit = 1'b1;
        default:                     hit = is_pc_mask;
      endcase
    end
  end

  assign wr      = access & pwrite & hit;
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sense_q <= epiu_pkg::EPIU_RST_SENSE;
    end else if (ce && wr && idx == epiu_pkg::EPIU_IDX_SENSE) begin
      sense_q <= pwdata[epiu_pkg::EPIU_SENSE_BITS-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ext_mask_q <= epiu_pkg::EPIU_RST_EXT_MASK;
    end else if (ce && wr && idx == epiu_pkg::EPIU_IDX_EXT_MASK) begin
      ext_mask_q <= pwdata[NEXT-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      grp_en_q <= epiu_pkg::EPIU_RST_GRP_EN;
    end else if (ce && wr && idx == epiu_pkg::EPIU_IDX_GRP_EN) begin
      grp_en_q <= pwdata[NGRP-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int g = 0; g < NGRP; g++) begin
        pc_mask_q[g] <= epiu_pkg::EPIU_RST_PC_MASK;
      end
    end else if (ce && wr && is_pc_mask) begin
      pc_mask_q[pc_mask_sel] <= pwdata[GRPW-1:0];
    end
  end

  // read data captured in the setup phase
  always_comb begin
    rd_mux = 32'h00000000;
    if (addr_ok) begin
      case (idx)
        epiu_pkg::EPIU_IDX_PC_FLAG:  rd_mux[NGRP-1:0] = pc_flag_q;
        epiu_pkg::EPIU_IDX_EXT_FLAG: rd_mux[NEXT-1:0] = ext_flag_q;
        epiu_pkg::EPIU_IDX_EXT_MASK: rd_mux[NEXT-1:0] = ext_mask_q;
        epiu_pkg::EPIU_IDX_GRP_EN:   rd_mux[NGRP-1:0] = grp_en_q;
        epiu_pkg::EPIU_IDX_SENSE:    rd_mux[epiu_pkg::EPIU_SENSE_BITS-1:0] = sense_q;
        default: begin
          if (is_pc_mask) begin
            rd_mux[GRPW-1:0] = pc_mask_q[pc_mask_sel];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prdata_q <= 32'h00000000;
    end else if (ce && setup && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;

endmodule

// [include/epiu_pkg.sv]
// constants shared by the external pin interrupt unit
package epiu_pkg;

  localparam int unsigned EPIU_AW    = 12;
  localparam int unsigned EPIU_DW    = 32;
  localparam int unsigned EPIU_NEXT  = 3;
  localparam int unsigned EPIU_NGRP  = 4;
  localparam int unsigned EPIU_GRPW  = 8;
  localparam int unsigned EPIU_NPC   = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0] EPIU_IDX_PC_FLAG   = 8'h3B;
  localparam logic [7:0] EPIU_IDX_EXT_FLAG  = 8'h3C;
  localparam logic [7:0] EPIU_IDX_EXT_MASK  = 8'h3D;
  localparam logic [7:0] EPIU_IDX_GRP_EN    = 8'h68;
  localparam logic [7:0] EPIU_IDX_SENSE     = 8'h69;
  localparam logic [7:0] EPIU_IDX_PC_MASK0  = 8'h70;

  // sense control field layout
  localparam int unsigned EPIU_SENSE_W      = 2;
  localparam int unsigned EPIU_SENSE_POS0   = 0;
  localparam int unsigned EPIU_SENSE_POS1   = 2;
  localparam int unsigned EPIU_SENSE_POS2   = 4;
  localparam int unsigned EPIU_SENSE_BITS   = 6;

  // sense encodings
  localparam logic [1:0] EPIU_SENSE_LOW  = 2'h0;
  localparam logic [1:0] EPIU_SENSE_ANY  = 2'h1;
  localparam logic [1:0] EPIU_SENSE_FALL = 2'h2;
  localparam logic [1:0] EPIU_SENSE_RISE = 2'h3;

  // reset values
  localparam logic [5:0] EPIU_RST_SENSE    = 6'h00;
  localparam logic [2:0] EPIU_RST_EXT_MASK = 3'h0;
  localparam logic [2:0] EPIU_RST_EXT_FLAG = 3'h0;
  localparam logic [3:0] EPIU_RST_GRP_EN   = 4'h0;
  localparam logic [3:0] EPIU_RST_PC_FLAG  = 4'h0;
  localparam logic [7:0] EPIU_RST_PC_MASK  = 8'h00;

  // cycles after reset before sampled pins are trusted
  localparam logic [1:0] EPIU_PRIME_CYCLES = 2'h3;

endpackage

// [verilog/epiu_sync.sv]
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module epiu_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce) begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule

// [verilog/epiu_edge_sense.sv]
// edge and level sense for one dedicated pin
`timescale 1ns/1ps
module epiu_edge_sense (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       io_en,
  input  wire logic       armed,
  input  wire logic       pin_s,
  input  wire logic [1:0] sense,
  output logic            trig,
  output logic            level_low
);

  logic prev_q;
  logic rise;
  logic fall;

  // previous sample only advances while the io clock runs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prev_q <= 1'b0;
    end else if (ce && io_en) begin
      prev_q <= pin_s;
    end
  end

  assign rise = pin_s & ~prev_q;
  assign fall = ~pin_s & prev_q;

  always_comb begin
    trig = 1'b0;
    case (sense)
      epiu_pkg::EPIU_SENSE_ANY:  trig = rise | fall;
      epiu_pkg::EPIU_SENSE_FALL: trig = fall;
      epiu_pkg::EPIU_SENSE_RISE: trig = rise;
      default:                   trig = 1'b0;
    endcase
    trig = trig & armed & io_en;
  end

  assign level_low = (sense == epiu_pkg::EPIU_SENSE_LOW) & ~pin_s;

endmodule

// [tb/epiu_pin_drv.sv]
// board-side drivers of the dedicated and pin-change pins
`timescale 1ns/1ps
module epiu_pin_drv (
  input  wire logic        ref_clk,
  input  wire logic [2:0]  ext_set,
  input  wire logic [31:0] pc_set,
  output logic      [2:0]  ext_irq_pin = 3'h7,
  output logic      [31:0] pin_change_input = 32'h00000000
);
  // levels held for whole cycles until the bench commands a change
  always_ff @(posedge ref_clk) begin
    ext_irq_pin      <= ext_set;
    pin_change_input <= pc_set;
  end
endmodule

// [tb/epiu_top_chk.sv]
// port assertions for the external pin interrupt unit
`timescale 1ns/1ps
module epiu_top_chk (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pslverr,
  input wire logic [2:0]  ext_irq_pin,
  input wire logic [31:0] pin_change_input,
  input wire logic        global_irq_en,
  input wire logic        sleep_en,
  input wire logic        sleep_idle,
  input wire logic        startup_busy,
  input wire logic [2:0]  ext_irq_ack,
  input wire logic [3:0]  pc_group_ack,
  input wire logic [2:0]  ext_irq_req,
  input wire logic [3:0]  pc_group_req,
  input wire logic        wake_req
);
  wire logic apb_wr = psel && penable && pwrite;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_pc_quiet;
    $stable(pin_change_input[31:24]) [*4];
  endsequence
  sequence s_pin0_high;
    ext_irq_pin[0] [*4];
  endsequence
  sequence s_deep_high;
    (ext_irq_pin[0] && sleep_en && !sleep_idle) [*3];
  endsequence
  property p_ext_gate;
    |ext_irq_req |-> global_irq_en;
  endproperty
  property p_pc_gate;
    |pc_group_req |-> global_irq_en;
  endproperty
  property p_wake_gate;
    wake_req |-> global_irq_en;
  endproperty
  property p_rst_clear;
    $rose(nrst) && $past(ce) |-> ext_irq_req == 3'h0 && pc_group_req == 4'h0 && !wake_req;
  endproperty
  property p_pc_ack;
    s_pc_quiet ##0 (pc_group_ack[3] && ce && !apb_wr) |=> !pc_group_req[3];
  endproperty
  property p_ext_ack;
    s_pin0_high ##0 (ext_irq_ack[0] && ce && !apb_wr) |=> !ext_irq_req[0];
  endproperty
  property p_level_hold;
    (!ext_irq_pin[0]) [*3] ##0 (ext_irq_req[0] && !ext_irq_ack[0] && !apb_wr && ce)
      |=> ext_irq_req[0] || !global_irq_en || startup_busy;
  endproperty
  property p_sleep_edge;
    s_deep_high ##0 (!ext_irq_req[0] && !apb_wr)
      |=> !ext_irq_req[0] || $changed(global_irq_en) || $fell(startup_busy);
  endproperty
  property p_err_access;
    pslverr |-> psel && penable;
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("pin request without global flag");
  a_pc_gate: assert property (p_pc_gate) else $error("group request without global flag");
  a_wake_gate: assert property (p_wake_gate) else $error("wake without global flag");
  a_rst_clear: assert property (p_rst_clear) else $error("request after reset");
  a_pc_ack: assert property (p_pc_ack) else $error("group request survives ack");
  a_ext_ack: assert property (p_ext_ack) else $error("pin request survives ack");
  a_level_hold: assert property (p_level_hold) else $error("low level request dropped");
  a_sleep_edge: assert property (p_sleep_edge) else $error("edge request with io clock stopped");
  a_err_access: assert property (p_err_access) else $error("slave error outside access phase");
endmodule

bind epiu_top epiu_top_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin), .pin_change_input(pin_change_input),
  .global_irq_en(global_irq_en), .sleep_en(sleep_en), .sleep_idle(sleep_idle), .startup_busy(startup_busy),
  .ext_irq_ack(ext_irq_ack), .pc_group_ack(pc_group_ack), .ext_irq_req(ext_irq_req),
  .pc_group_req(pc_group_req), .wake_req(wake_req));

// [tb/tb_top.sv]
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  ext_set = 3'h7;
  logic [31:0] pc_set = 32'h00000000;
  logic [2:0]  ext_irq_pin;
  logic [31:0] pin_change_input;
  logic        global_irq_en = 1'b1;
  logic        sleep_en = 1'b0;
  logic        sleep_idle = 1'b0;
  logic        startup_busy = 1'b0;
  logic [2:0]  ext_irq_ack = 3'h0;
  logic [3:0]  pc_group_ack = 4'h0;
  logic [2:0]  ext_irq_req;
  logic [3:0]  pc_group_req;
  logic        wake_req;
  logic [31:0] rd;
  logic        last_err;
  int          n_fail = 0;
  int          total_checks = 0;
  // row: pin[6:5] sense[4:3] start[2] end[1] expect[0]
  logic [6:0]  rows [9] = '{7'h0D, 7'h15, 7'h12, 7'h3B, 7'h3C, 7'h45, 7'h42, 7'h4B, 7'h35};
  logic [7:0]  regs [6] = '{8'h3B, 8'h3C, 8'h3D, 8'h68, 8'h69, 8'h70};

  always #10 ref_clk = ~ref_clk;

  epiu_top DUT (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin(ext_irq_pin), .pin_change_input(pin_change_input), .global_irq_en(global_irq_en),
    .sleep_en(sleep_en), .sleep_idle(sleep_idle), .startup_busy(startup_busy), .ext_irq_ack(ext_irq_ack),
    .pc_group_ack(pc_group_ack), .ext_irq_req(ext_irq_req), .pc_group_req(pc_group_req), .wake_req(wake_req));
  epiu_pin_drv u_pins (.ref_clk(ref_clk), .ext_set(ext_set), .pc_set(pc_set), .ext_irq_pin(ext_irq_pin),
    .pin_change_input(pin_change_input));

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    paddr <= {2'h0, idx, 2'h0};
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    complete_run();
  end

  initial begin
    tick(2);
    nrst <= 1'b1;
    tick(4);
    foreach (rows[i]) begin
      ext_set[rows[i][6:5]] <= rows[i][2];
      tick(5);
      apb(1'b1, 8'h69, 32'(rows[i][4:3]) << (2 * rows[i][6:5]));
      apb(1'b0, 8'h69, 32'h00000000);
      chk("sense", 32'(rows[i][4:3]) << (2 * rows[i][6:5]), rd);
      apb(1'b1, 8'h3D, 32'h00000001 << rows[i][6:5]);
      apb(1'b1, 8'h3C, 32'h00000007);
      ext_set[rows[i][6:5]] <= rows[i][1];
      tick(6);
      chk("ext_irq_req", 32'(rows[i][0]) << rows[i][6:5], 32'(ext_irq_req));
    end
    apb(1'b1, 8'h69, 32'h00000002);
    apb(1'b1, 8'h3D, 32'h00000001);
    ext_set <= 3'h7;
    global_irq_en <= 1'b0;
    tick(5);
    apb(1'b1, 8'h3C, 32'h00000007);
    ext_set[0] <= 1'b0;
    tick(6);
    chk("req_gated", 32'h00000000, 32'(ext_irq_req));
    global_irq_en <= 1'b1;
    tick(1);
    chk("req_open", 32'h00000001, 32'(ext_irq_req));
    apb(1'b1, 8'h3C, 32'h00000001);
    chk("req_w1c", 32'h00000000, 32'(ext_irq_req));
    ext_set[0] <= 1'b1;
    tick(3);
    ext_set[0] <= 1'b0;
    tick(4);
    ext_set[0] <= 1'b1;
    tick(6);
    ext_irq_ack <= 3'h1;
    tick(1);
    ext_irq_ack <= 3'h0;
    tick(1);
    chk("req_ack", 32'h00000000, 32'(ext_irq_req));
    ext_set[0] <= 1'b0;
    apb(1'b1, 8'h69, 32'h00000003);
    apb(1'b1, 8'h3C, 32'h00000007);
    sleep_en <= 1'b1;
    tick(2);
    ext_set[0] <= 1'b1;
    tick(6);
    chk("req_sleep", 32'h00000000, 32'(ext_irq_req));
    ext_set[0] <= 1'b0;
    tick(4);
    sleep_idle <= 1'b1;
    tick(2);
    ext_set[0] <= 1'b1;
    tick(6);
    chk("req_idle", 32'h00000001, 32'(ext_irq_req));
    sleep_en <= 1'b0;
    sleep_idle <= 1'b0;
    apb(1'b1, 8'h69, 32'h00000000);
    startup_busy <= 1'b1;
    sleep_en <= 1'b1;
    ext_set[0] <= 1'b0;
    tick(2);
    chk("wake_level", 32'h00000001, 32'(wake_req));
    tick(4);
    chk("req_busy", 32'h00000000, 32'(ext_irq_req));
    startup_busy <= 1'b0;
    sleep_en <= 1'b0;
    tick(10);
    chk("req_low", 32'h00000001, 32'(ext_irq_req));
    ext_set[0] <= 1'b1;
    apb(1'b1, 8'h73, 32'h00000001);
    apb(1'b1, 8'h68, 32'h00000008);
    pc_set[25] <= 1'b1;
    tick(6);
    chk("pc_unmasked", 32'h00000000, 32'(pc_group_req));
    pc_set[24] <= 1'b1;
    tick(2);
    chk("wake_pc", 32'h00000001, 32'(wake_req));
    tick(4);
    chk("pc_req", 32'h00000008, 32'(pc_group_req));
    apb(1'b1, 8'h68, 32'h00000000);
    chk("pc_disabled", 32'h00000000, 32'(pc_group_req));
    apb(1'b1, 8'h68, 32'h00000008);
    pc_group_ack <= 4'h8;
    tick(1);
    pc_group_ack <= 4'h0;
    tick(1);
    chk("pc_ack", 32'h00000000, 32'(pc_group_req));
    apb(1'b0, 8'h00, 32'h00000000);
    chk("pslverr", 32'h00000001, 32'(last_err));
    chk("pready", 32'h00000001, 32'(pready));
    // bus write must be ignored while the clock enable is low
    ce <= 1'b0;
    apb(1'b1, 8'h3D, 32'h00000006);
    ce <= 1'b1;
    apb(1'b0, 8'h3D, 32'h00000000);
    chk("ce_hold", 32'h00000001, rd);
    apb(1'b1, 8'h69, 32'h0000003F);
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h00000000);
      chk("reset_value", 32'h00000000, rd);
    end
    complete_run();
  end
endmodule
